// *** logic/ger_error_reporter.sv ***
`timescale 1ns/100ps
`default_nettype none
module ger_error_reporter
  import ger_pkg::*;
#(
  parameter int BLINK_PERIOD_CYC = BLINK_CYC,
  parameter int FLASH_LEN_CYC    = FLASH_CYC
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        CAN_RX_QUEUE_OVF_IN,
  input  wire logic        CAN_TX_QUEUE_OVF_IN,
  input  wire logic        CAN_CTRL_OVF_IN,
  input  wire logic        CAN_ACK_ERR_IN,
  input  wire logic        CAN_WARN_IN,
  input  wire logic        CAN_PASSIVE_IN,
  input  wire logic        CAN_BUS_OFF_IN,
  input  wire logic        CAN_CTRL_FAULT_IN,
  input  wire logic        CAN_MSG_OK_IN,
  input  wire logic        CAN_HP_OVF_IN,
  input  wire logic        LINK_CONNECTED_IN,
  input  wire logic        LINK_TRANSFER_IN,
  input  wire logic        LINK_TX_QUEUE_OVF_IN,
  input  wire logic        LINK_RX_QUEUE_OVF_IN,
  input  wire logic        LINK_TX_FAIL_IN,
  input  wire logic        LINK_RX_FAIL_IN,
  output logic             ETH_ERR_LED_OUT,
  output logic             CAN_ERR_LED_OUT,
  output logic             LINK_DISCARD_OUT,
  output logic             CAN_TX_RETRY_OUT,
  output logic             EMCY_VALID_OUT,
  input  wire logic        EMCY_READY_IN,
  output logic [10:0]      EMCY_ID_OUT,
  output logic [63:0]      EMCY_DATA_OUT
);
  logic        aw_held_r;
  logic [7:0]  awaddr_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] byte_mask;
  logic [31:0] ctrl_r;
  logic [15:0] clr_vec;
  logic [15:0] set_vec;
  logic [15:0] mask_r;
  logic [15:0] err_mask;
  logic [15:0] state_word;
  logic        eth_latch_r;
  logic        eth_clr;
  logic        bus_off_q_r;
  logic        conn_q_r;
  logic        err_any_q_r;
  logic        bus_off_blink_r;
  logic        ack_blink_r;
  logic        ev_new;
  logic        ev_bus_on;
  logic        ev_ok;
  logic        pend_r;
  logic [15:0] pend_code_r;
  ger_state_t  state_r;
  ger_state_t  state_nxt;
  logic [63:0] frame_r;
  logic [10:0] emcy_id_r;

  // ****************************************
  // Register bus
  // ****************************************
  assign S_AXI_AWREADY_OUT = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY_OUT  = !w_held_r && !bvalid_r;
  assign S_AXI_ARREADY_OUT = !rvalid_r;
  assign S_AXI_BVALID_OUT  = bvalid_r;
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_RVALID_OUT  = rvalid_r;
  assign S_AXI_RRESP_OUT   = rresp_r;
  assign S_AXI_RDATA_OUT   = rdata_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign rd_fire = S_AXI_ARVALID_IN && !rvalid_r;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign byte_mask[8*b+7:8*b] = {8{wstrb_r[b]}};
    end
  endgenerate

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= S_AXI_AWADDR_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || wr_fire) begin
      w_held_r <= 1'b0;
    end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_held_r <= 1'b1;
      wdata_r  <= S_AXI_WDATA_IN;
      wstrb_r  <= S_AXI_WSTRB_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == OFS_CTRL || awaddr_r == OFS_CLEAR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        OFS_CTRL:     rdata_r <= ctrl_r;
        OFS_STATE:    rdata_r <= {16'h0, state_word};
        OFS_CLEAR:    rdata_r <= 32'h0;
        OFS_FRAME_LO: rdata_r <= frame_r[31:0];
        OFS_FRAME_HI: rdata_r <= frame_r[63:32];
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_fire && awaddr_r == OFS_CTRL) begin
      ctrl_r <= (ctrl_r & ~(byte_mask & CTRL_WMASK)) | (wdata_r & byte_mask & CTRL_WMASK);
    end
  end

  assign clr_vec = (wr_fire && awaddr_r == OFS_CLEAR) ? (wdata_r[15:0] & byte_mask[15:0])
                                                       : 16'h0;
  // Latch clear sits above the mask bits, in the third byte lane
  assign eth_clr = wr_fire && awaddr_r == OFS_CLEAR && wdata_r[CLR_ETH_BIT]
                   && wstrb_r[CLR_ETH_BIT / 8];

  // ****************************************
  // Error mask
  // ****************************************
  always_comb begin
    set_vec = 16'h0;
    set_vec[B_RX_OVF]     = CAN_RX_QUEUE_OVF_IN || LINK_RX_QUEUE_OVF_IN;
    set_vec[B_TX_OVF]     = CAN_TX_QUEUE_OVF_IN || LINK_TX_QUEUE_OVF_IN;
    set_vec[B_CTL_OVF]    = CAN_CTRL_OVF_IN;
    set_vec[B_ACK]        = CAN_ACK_ERR_IN;
    set_vec[B_WARN]       = CAN_WARN_IN;
    set_vec[B_PASSIVE]    = CAN_PASSIVE_IN;
    set_vec[B_TX_ERR]     = LINK_TX_FAIL_IN;
    set_vec[B_RX_ERR]     = LINK_RX_FAIL_IN;
    set_vec[B_TERMINATED] = conn_q_r && !LINK_CONNECTED_IN;
    set_vec[B_GENERIC]    = CAN_CTRL_FAULT_IN;
  end

  generate
    for (genvar i = 0; i < 16; i++) begin : g_mask
      always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
          mask_r[i] <= 1'b0;
        end else begin
          mask_r[i] <= set_vec[i] || (mask_r[i] && !clr_vec[i]);
        end
      end
    end
  endgenerate

  assign err_mask = mask_r | (16'(CAN_BUS_OFF_IN) << B_BUS_OFF);
  assign state_word = err_mask | (16'(LINK_CONNECTED_IN) << B_CONNECTED)
                               | (16'(LINK_TRANSFER_IN) << B_TRANSFER);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      bus_off_q_r <= 1'b0;
      conn_q_r    <= 1'b0;
      err_any_q_r <= 1'b0;
    end else begin
      bus_off_q_r <= CAN_BUS_OFF_IN;
      conn_q_r    <= LINK_CONNECTED_IN;
      err_any_q_r <= err_mask != 16'h0;
    end
  end

  // ****************************************
  // Ethernet side indication
  // ****************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      eth_latch_r <= 1'b0;
    end else begin
      eth_latch_r <= LINK_TX_QUEUE_OVF_IN || LINK_RX_QUEUE_OVF_IN || LINK_TX_FAIL_IN
                  || LINK_RX_FAIL_IN || (eth_latch_r && !eth_clr);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ETH_ERR_LED_OUT  <= 1'b0;
      LINK_DISCARD_OUT <= 1'b0;
      CAN_TX_RETRY_OUT <= 1'b0;
    end else begin
      ETH_ERR_LED_OUT  <= !LINK_CONNECTED_IN || eth_latch_r || LINK_TX_QUEUE_OVF_IN
                       || LINK_RX_QUEUE_OVF_IN || LINK_TX_FAIL_IN || LINK_RX_FAIL_IN;
      LINK_DISCARD_OUT <= LINK_TX_FAIL_IN || LINK_RX_FAIL_IN;
      CAN_TX_RETRY_OUT <= CAN_TX_QUEUE_OVF_IN;
    end
  end

  // ****************************************
  // CAN side indication
  // ****************************************
  // blink until success
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      bus_off_blink_r <= 1'b0;
      ack_blink_r     <= 1'b0;
    end else begin
      bus_off_blink_r <= CAN_BUS_OFF_IN || (bus_off_blink_r && !CAN_MSG_OK_IN);
      ack_blink_r     <= CAN_ACK_ERR_IN || (ack_blink_r && !CAN_MSG_OK_IN);
    end
  end

  ger_led_pattern #(
    .PERIOD_CYC (BLINK_PERIOD_CYC),
    .FLASH_LEN  (FLASH_LEN_CYC)
  ) u_can_led (
    .clk_in          (SYS_CLK_IN),
    .rst_in          (SYS_RST_IN),
    .bus_off_mode_in (bus_off_blink_r),
    .ack_mode_in     (ack_blink_r),
    .flash_in        (CAN_RX_QUEUE_OVF_IN || CAN_TX_QUEUE_OVF_IN),
    .led_out         (CAN_ERR_LED_OUT)
  );

  // ****************************************
  // Emergency frames
  // ****************************************
  assign ev_new    = (|(set_vec & ~mask_r)) || (CAN_BUS_OFF_IN && !bus_off_q_r);
  assign ev_bus_on = bus_off_q_r && !CAN_BUS_OFF_IN;
  assign ev_ok     = err_any_q_r && err_mask == 16'h0;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pend_r      <= 1'b0;
      pend_code_r <= EMCY_NONE;
    end else begin
      if (state_r == ST_IDLE) begin
        pend_r <= 1'b0;
      end
      if (ev_new) begin
        pend_r      <= 1'b1;
        pend_code_r <= EMCY_NEW;
      end else if (ev_bus_on) begin
        pend_r      <= 1'b1;
        pend_code_r <= EMCY_BUS_ON;
      end else if (ev_ok) begin
        pend_r      <= 1'b1;
        pend_code_r <= EMCY_NONE;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (pend_r && ctrl_r[CTRL_EN_BIT]) state_nxt = ST_BUILD;
      ST_BUILD: if (!CAN_HP_OVF_IN) state_nxt = ST_SEND;
      ST_SEND:  if (EMCY_READY_IN) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      frame_r   <= 64'h0;
      emcy_id_r <= 11'h0;
    end else if (state_r == ST_IDLE && state_nxt == ST_BUILD) begin
      frame_r   <= {16'h0, err_mask[15:8], err_mask[7:0], ctrl_r[CTRL_IF_LSB +: 8],
                    (err_mask != 16'h0) ? ERR_REG_SET : ERR_REG_CLR,
                    pend_code_r[15:8], pend_code_r[7:0]};
      emcy_id_r <= ctrl_r[CTRL_ID_LSB +: 11];
    end
  end

  assign EMCY_VALID_OUT = state_r == ST_SEND;
  assign EMCY_DATA_OUT  = frame_r;
  assign EMCY_ID_OUT    = emcy_id_r;

  // ****************************************
  // Checks
  // ****************************************
  no_link_led_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    !LINK_CONNECTED_IN |=> ETH_ERR_LED_OUT)
    else $error("Ethernet LED dark without link");
  link_ovf_led_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    LINK_TX_QUEUE_OVF_IN || LINK_RX_QUEUE_OVF_IN |=> ETH_ERR_LED_OUT ##1 ETH_ERR_LED_OUT)
    else $error("Ethernet LED not held after overflow");
  fail_discard_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    LINK_TX_FAIL_IN || LINK_RX_FAIL_IN |=> LINK_DISCARD_OUT && ETH_ERR_LED_OUT)
    else $error("failure did not discard");
  tx_retry_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    CAN_TX_RETRY_OUT |-> $past(CAN_TX_QUEUE_OVF_IN))
    else $error("retry without overflow");
  hp_block_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    $rose(EMCY_VALID_OUT) |-> !$past(CAN_HP_OVF_IN))
    else $error("frame inserted during high-priority overflow");
  emcy_code_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    EMCY_VALID_OUT |-> EMCY_DATA_OUT[15:0] inside {16'h1000, 16'h8140, 16'h0000})
    else $error("bad emergency code bytes");
  err_reg_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    EMCY_VALID_OUT |-> EMCY_DATA_OUT[23:16] == ((EMCY_DATA_OUT[47:32] != 16'h0) ? 8'h80 : 8'h00))
    else $error("error register mismatch");
  rx_ovf_bit_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    CAN_RX_QUEUE_OVF_IN |=> state_word[0] until_with clr_vec[0])
    else $error("receive overflow bit not held");
  conn_state_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    state_word[B_CONNECTED] == LINK_CONNECTED_IN && state_word[B_TRANSFER] == LINK_TRANSFER_IN
      && state_word[B_BUS_OFF] == (CAN_BUS_OFF_IN || mask_r[B_BUS_OFF]))
    else $error("state word bits wrong");
  busoff_blink_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
    $rose(CAN_BUS_OFF_IN) |=> bus_off_blink_r [*2])
    else $error("bus-off blink not started");
endmodule
`default_nettype wire

// *** logic/ger_led_pattern.sv ***
`timescale 1ns/100ps
`default_nettype none
module ger_led_pattern
  import ger_pkg::*;
#(
  parameter int PERIOD_CYC = BLINK_CYC,
  parameter int FLASH_LEN  = FLASH_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic bus_off_mode_in,
  input  wire logic ack_mode_in,
  input  wire logic flash_in,
  output logic      led_out
);
  logic [31:0] phase_r;
  logic [31:0] flash_r;
  logic        led_nxt;

  // ****************************************
  // Pattern timers
  // ****************************************
  // cycle count parameters
  always_ff @(posedge clk_in) begin
    if (rst_in || phase_r == 32'(PERIOD_CYC - 1)) begin
      phase_r <= 32'h0;
    end else begin
      phase_r <= phase_r + 32'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flash_r <= 32'h0;
    end else if (flash_in) begin
      flash_r <= 32'(FLASH_LEN);
    end else if (flash_r != 32'h0) begin
      flash_r <= flash_r - 32'h1;
    end
  end

  always_comb begin
    if (bus_off_mode_in) begin
      led_nxt = phase_r < 32'(PERIOD_CYC / 2);
    end else if (ack_mode_in) begin
      led_nxt = phase_r < 32'(PERIOD_CYC / 4);
    end else begin
      led_nxt = flash_r != 32'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      led_out <= 1'b0;
    end else begin
      led_out <= led_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  half_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_off_mode_in |-> ##1 led_out == $past(phase_r < 32'(PERIOD_CYC / 2)))
    else $error("bus-off blink phase wrong");
  quarter_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ack_mode_in && !bus_off_mode_in
      |-> ##1 led_out == $past(phase_r < 32'(PERIOD_CYC / 4)))
    else $error("ack blink phase wrong");
endmodule
`default_nettype wire

// *** logic/ger_pkg.sv ***
// Functional notes
// - Ethernet LED steady while no tunnel connection exists or it dropped.
// - Tunnel transmit queue overflow lights Ethernet LED; message counts as lost.
// - Tunnel receive queue overflow lights Ethernet LED; message counts as lost.
// - Tunnel send or receive failure lights Ethernet LED.
// - Tunnel failure discards pending CAN-to-network send contents.
// - CAN receive queue overflow gives short CAN LED flash.
// - CAN transmit queue overflow flashes CAN LED and retries the original message.
// - Emergency frame inserted only while high-priority CAN buffer not overflowed.
// - Bus-off blinks CAN LED 50:50 until a message succeeds.
// - Acknowledge error blinks CAN LED 25:75 until a message succeeds.
// - Emergency frames enabled with configurable identifier, default 0xFE.
// - Frame: code 0-1, error register 2, interface 3, mask 4-5, reserved 6-7.
// - Code 0x1000 new error, 0x8140 leaving bus-off, 0x0000 no errors.
// - Error register 0x80 while errors remain, 0x00 once all cleared.
// - Two-byte fields sent least significant byte first.
// - Mask bits 0x0001 receive, 0x0002 transmit, 0x0004 controller overflow.
// - Mask bits 0x0008 acknowledge, 0x0010 warning, 0x0020 error-passive.
// - Mask bits 0x0040 while bus-off, 0x2000 generic controller fault.
// - Mask bits 0x0080 transmit error, 0x0100 receive error, 0x0400 terminated.
// - State word adds 0x0200 while connected, 0x0800 while transferring.
package ger_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATE     = 8'h04;
  localparam logic [7:0]  OFS_CLEAR     = 8'h08;
  localparam logic [7:0]  OFS_FRAME_LO  = 8'h0c;
  localparam logic [7:0]  OFS_FRAME_HI  = 8'h10;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_IF_LSB   = 8;
  localparam int          CTRL_ID_LSB   = 16;
  localparam int          CLR_ETH_BIT   = 16;
  localparam logic [31:0] CTRL_WMASK    = 32'h07ff_ff01;
  localparam logic [31:0] CTRL_RESET    = 32'h00fe_0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ****************************************
  // Error mask and state bits
  // ****************************************
  localparam int          B_RX_OVF      = 0;
  localparam int          B_TX_OVF      = 1;
  localparam int          B_CTL_OVF     = 2;
  localparam int          B_ACK         = 3;
  localparam int          B_WARN        = 4;
  localparam int          B_PASSIVE     = 5;
  localparam int          B_BUS_OFF     = 6;
  localparam int          B_TX_ERR      = 7;
  localparam int          B_RX_ERR      = 8;
  localparam int          B_CONNECTED   = 9;
  localparam int          B_TERMINATED  = 10;
  localparam int          B_TRANSFER    = 11;
  localparam int          B_GENERIC     = 13;
  // ****************************************
  // Emergency frame values
  // ****************************************
  localparam logic [15:0] EMCY_NEW      = 16'h1000;
  localparam logic [15:0] EMCY_BUS_ON   = 16'h8140;
  localparam logic [15:0] EMCY_NONE     = 16'h0000;
  localparam logic [7:0]  ERR_REG_SET   = 8'h80;
  localparam logic [7:0]  ERR_REG_CLR   = 8'h00;
  // ****************************************
  // LED timing
  // ****************************************
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          BLINK_MS      = 500;
  localparam int          FLASH_MS      = 50;
  localparam int          BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);
  localparam int          FLASH_CYC     = FLASH_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUILD = 2'b01,
    ST_SEND  = 2'b11
  } ger_state_t;
endpackage

// *** tb/ger_can_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
module ger_can_peer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [2:0]  delay_in,
  input  wire logic        valid_in,
  input  wire logic [10:0] id_in,
  input  wire logic [63:0] data_in,
  output logic             ready_out
);
  logic [2:0]  wait_r;
  logic [63:0] frames[$];
  logic [10:0] ids[$];
  // ****
  // Frame acceptance, slow or prompt
  // ****
  always @(posedge clk_in) begin
    if (rst_in || !valid_in) begin
      wait_r    <= 3'h0;
      ready_out <= 1'b0;
    end else if (ready_out) begin
      frames.push_back(data_in);
      ids.push_back(id_in);
      ready_out <= 1'b0;
    end else if (wait_r >= delay_in) begin
      ready_out <= 1'b1;
    end else begin
      wait_r <= wait_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_gateway_error_reporter.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_gateway_error_reporter import ger_pkg::*; ;
  localparam int PER = 16;
  localparam int FL  = 4;
  localparam logic [15:0] MSK [16] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h20, 16'h0,
    16'h2000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2, 16'h1, 16'h80, 16'h100};
  logic        clk = 1'b0, rst = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
  logic        ar_v = 1'b0, r_r = 1'b0, awrdy, wrdy, bv, arrdy, rv, eth, can, disc, retry;
  logic        e_v, e_rdy;
  logic [7:0]  aw_a = 8'h0, ar_a = 8'h0, ifn = 8'h0;
  logic [31:0] w_d = 32'h0, rdata, lf = 32'hdeab;
  logic [3:0]  w_s = 4'hf;
  logic [1:0]  bresp, rresp;
  logic [15:0] ev = 16'h0;
  logic [2:0]  dly = 3'h0;
  logic [10:0] e_id, idv = 11'h0fe;
  logic [63:0] e_d;
  int          fail_count = 0, samples_checked = 0;
  always #10 clk = ~clk;
  ger_error_reporter #(.BLINK_PERIOD_CYC(PER), .FLASH_LEN_CYC(FL)) u_dut (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
    .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(w_s),
    .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(b_r), .S_AXI_ARADDR_IN(ar_a),
    .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(r_r),
    .CAN_RX_QUEUE_OVF_IN(ev[0]), .CAN_TX_QUEUE_OVF_IN(ev[1]), .CAN_CTRL_OVF_IN(ev[2]),
    .CAN_ACK_ERR_IN(ev[3]), .CAN_WARN_IN(ev[4]), .CAN_PASSIVE_IN(ev[5]),
    .CAN_BUS_OFF_IN(ev[6]), .CAN_CTRL_FAULT_IN(ev[7]), .CAN_MSG_OK_IN(ev[8]),
    .CAN_HP_OVF_IN(ev[9]), .LINK_CONNECTED_IN(ev[10]), .LINK_TRANSFER_IN(ev[11]),
    .LINK_TX_QUEUE_OVF_IN(ev[12]), .LINK_RX_QUEUE_OVF_IN(ev[13]),
    .LINK_TX_FAIL_IN(ev[14]), .LINK_RX_FAIL_IN(ev[15]), .ETH_ERR_LED_OUT(eth),
    .CAN_ERR_LED_OUT(can), .LINK_DISCARD_OUT(disc), .CAN_TX_RETRY_OUT(retry),
    .EMCY_VALID_OUT(e_v), .EMCY_READY_IN(e_rdy), .EMCY_ID_OUT(e_id), .EMCY_DATA_OUT(e_d));
  ger_can_peer u_peer (.clk_in(clk), .rst_in(rst), .delay_in(dly), .valid_in(e_v),
    .id_in(e_id), .data_in(e_d), .ready_out(e_rdy));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] fx(input logic [15:0] c, input logic [7:0] e,
                                     input logic [15:0] m);
    return {16'h0, m, ifn, e, c};
  endfunction
  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ao, wo;
    ao = 0;
    wo = 0;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 200 && !(ao && wo); n++) begin
      @(posedge clk);
      if (!ao && awrdy === 1'b1) begin
        ao = 1;
        aw_v <= 1'b0;
      end
      if (!wo && wrdy === 1'b1) begin
        wo = 1;
        w_v <= 1'b0;
      end
    end
    tmo(n);
    for (n = 0; n < 200 && bv !== 1'b1; n++) @(posedge clk);
    tmo(n);
    chk(bresp, er);
    b_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arrdy === 1'b1) break;
    end
    tmo(n);
    ar_v <= 1'b0;
    for (n = 0; n < 200 && rv !== 1'b1; n++) @(posedge clk);
    tmo(n);
    chk(rdata, ed);
    chk(rresp, er);
    r_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pls(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cnt(input int e);
    int c;
    c = 0;
    repeat (PER) begin
      @(posedge clk);
      if (can === 1'b1) c++;
    end
    chk(c, e);
  endtask
  task automatic frm(input logic [15:0] c, input logic [7:0] e, input logic [15:0] m,
                     input bit full);
    int n;
    logic [63:0] d;
    dly <= lf[2:0];
    lf = nx(lf);
    for (n = 0; n < 200 && u_peer.frames.size() == 0; n++) @(posedge clk);
    tmo(n);
    d = u_peer.frames.pop_front();
    chk(u_peer.ids.pop_front(), idv);
    if (full) chk(d, fx(c, e, m));
    else chk(d[15:0], c);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(eth, 1);
    rdc(OFS_CTRL, {5'h0, 11'h0fe, 16'h0001}, RESP_OKAY);
    rdc(8'h14, 32'h0, RESP_SLVERR);
    wr(OFS_STATE, 32'hffff, RESP_SLVERR);
    ev[10] <= 1'b1;
    repeat (2) @(posedge clk);
    chk(eth, 0);
    for (int i = 0; i < 16; i++) begin
      if (MSK[i] == 16'h0) continue;
      wr(OFS_CLEAR, 32'h1_ffff, RESP_OKAY);
      ev[11] <= lf[0];
      lf = nx(lf);
      pls(i);
      chk(eth, i >= 12);
      chk(disc, i >= 14);
      chk(retry, i == 1);
      rdc(OFS_STATE, {16'h0, MSK[i] | (ev[11] ? 16'h0a00 : 16'h0200)}, RESP_OKAY);
    end
    wr(OFS_CLEAR, 32'h1_ffff, RESP_OKAY);
    ev[11:10] <= 2'b00;
    repeat (2) @(posedge clk);
    chk(eth, 1);
    rdc(OFS_STATE, 32'h0400, RESP_OKAY);
    ev[10] <= 1'b1;
    pls(8);
    pls(3);
    ev[6] <= 1'b1;
    repeat (4) @(posedge clk);
    cnt(PER / 2);
    rdc(OFS_STATE, 32'h0648, RESP_OKAY);
    ev[6] <= 1'b0;
    repeat (4) @(posedge clk);
    cnt(PER / 2);
    pls(8);
    repeat (2) @(posedge clk);
    cnt(0);
    pls(3);
    repeat (2) @(posedge clk);
    cnt(PER / 4);
    pls(8);
    for (int i = 0; i < 2; i++) begin
      pls(i);
      cnt(FL);
    end
    wr(OFS_CLEAR, 32'h1_ffff, RESP_OKAY);
    repeat (40) @(posedge clk);
    u_peer.frames.delete();
    u_peer.ids.delete();
    ifn = lf[7:0];
    idv = lf[18:8];
    lf = nx(lf);
    wr(OFS_CTRL, {5'h0, idv, ifn, 8'h01}, RESP_OKAY);
    pls(3);
    frm(16'h1000, 8'h80, 16'h0008, 1);
    wr(OFS_CLEAR, 32'hffff, RESP_OKAY);
    frm(16'h0000, 8'h00, 16'h0000, 1);
    ev[6] <= 1'b1;
    frm(16'h1000, 8'h80, 16'h0040, 1);
    ev[6] <= 1'b0;
    frm(16'h8140, 8'h00, 16'h0000, 0);
    pls(5);
    frm(16'h1000, 8'h80, 16'h0020, 1);
    wr(OFS_CLEAR, 32'hffff, RESP_OKAY);
    frm(16'h0000, 8'h00, 16'h0000, 1);
    ev[9] <= 1'b1;
    pls(4);
    repeat (10) @(posedge clk);
    chk(e_v, 0);
    ev[9] <= 1'b0;
    frm(16'h1000, 8'h80, 16'h0010, 1);
    wr(OFS_CTRL, {5'h0, idv, ifn, 8'h00}, RESP_OKAY);
    pls(5);
    repeat (20) @(posedge clk);
    chk(u_peer.frames.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
